// ==== logic/alu_pkg.sv ====
// Constants, types and helpers shared by the CPU arithmetic datapath.
// Assumes a single 20 MHz core clock with a synchronous reset.
package alu_pkg;

  // Register bus byte offsets
  localparam logic [6:0] STATUS_OFS = 7'h00;
  localparam logic [6:0] CONTROL_OFS = 7'h04;
  localparam logic [6:0] WREG_BASE = 7'h40;

  // alu_status field positions
  localparam int C_BIT = 0;
  localparam int Z_BIT = 1;
  localparam int OV_BIT = 2;
  localparam int N_BIT = 3;
  localparam int RA_BIT = 4;
  localparam int IPL_LSB = 5;
  localparam int IPL_MSB = 7;
  localparam int DC_BIT = 8;

  // core_control field positions
  localparam int TOP_BIT = 3;
  localparam int CTRL_RSVD_BIT = 2;

  // Reset values
  localparam logic FLAG_RST = 1'b0;
  localparam logic [2:0] IPL_RST = 3'h0;
  localparam logic TOP_RST = 1'b0;
  localparam logic CTRL_RSVD_VAL = 1'b1;
  localparam logic [15:0] WREG_RST = 16'h0000;

  // Divider: one step per divisor bit
  localparam int DIV_STEPS = 16;
  localparam logic [3:0] DIV_LAST = 4'(DIV_STEPS - 1);
  localparam logic [3:0] QUOT_REG = 4'h0;
  localparam logic [3:0] REM_REG = 4'h1;

  typedef enum logic [4:0] {
    OP_MOV, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
    OP_SL1, OP_LSR1, OP_ASR1,
    OP_SHL, OP_LSR, OP_ASR,
    OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_US,
    OP_MUL_SL, OP_MUL_UL, OP_MUL_BB,
    OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16
  } op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DIV} state_t;

  typedef struct packed {
    logic [15:0] res;
    logic c;
    logic dc;
    logic ov;
  } arith_t;

  function automatic logic is_div(input op_t op);
    return op inside {OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16};
  endfunction

  function automatic logic is_mbshift(input op_t op);
    return op inside {OP_SHL, OP_LSR, OP_ASR};
  endfunction

  function automatic logic is_mul(input op_t op);
    return op inside {OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_US,
                      OP_MUL_SL, OP_MUL_UL, OP_MUL_BB};
  endfunction

  // Carries taken from the byte or word boundaries as the size demands
  function automatic arith_t add_fn(input logic [15:0] a,
                                    input logic [15:0] b,
                                    input logic cin,
                                    input logic byte_mode);
    logic [16:0] s;
    logic [8:0] lo;
    logic [4:0] nib;
    arith_t r;
    s = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
    lo = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
    nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    r.res = s[15:0];
    if (byte_mode)
    begin
      r.c = lo[8];
      r.dc = nib[4];
      r.ov = (a[7] == b[7]) && (s[7] != a[7]);
    end
    else
    begin
      r.c = s[16];
      r.dc = lo[8];
      r.ov = (a[15] == b[15]) && (s[15] != a[15]);
    end
    return r;
  endfunction

  // Both operands widened to 17 bits so one signed multiplier covers
  // every sign mix
  function automatic logic [31:0] mul_fn(input logic [15:0] a,
                                         input logic [15:0] b,
                                         input logic a_s,
                                         input logic b_s);
    logic signed [16:0] x;
    logic signed [16:0] y;
    logic signed [33:0] p;
    x = {a_s & a[15], a};
    y = {b_s & b[15], b};
    p = x * y;
    return p[31:0];
  endfunction

endpackage

// ==== logic/regfile_if.sv ====
// Port bundle between the datapath and its working register array.
// Read data are registered; both write ports act at the clock edge.
`timescale 1ns/100ps
interface regfile_if;
  logic [3:0] ra_addr;
  logic [3:0] rb_addr;
  logic [3:0] rc_addr;
  logic [3:0] rd_addr;
  logic [15:0] ra_data;
  logic [15:0] rb_data;
  logic [15:0] rc_data;
  logic [15:0] rd_data;
  logic we0;
  logic we1;
  logic [3:0] wa0;
  logic [3:0] wa1;
  logic [15:0] wd0;
  logic [15:0] wd1;

  modport core (output ra_addr, rb_addr, rc_addr, rd_addr,
                output we0, we1, wa0, wa1, wd0, wd1,
                input ra_data, rb_data, rc_data, rd_data);
  modport mem (input ra_addr, rb_addr, rc_addr, rd_addr,
               input we0, we1, wa0, wa1, wd0, wd1,
               output ra_data, rb_data, rc_data, rd_data);
endinterface

// ==== logic/work_reg_file.sv ====
// Sixteen 16-bit working registers, four read ports, two write ports.
// Assumes the two write addresses differ whenever both ports write.
`timescale 1ns/100ps
module work_reg_file
  import alu_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Array access
  regfile_if.mem rf
);

  logic [15:0] mem_q [16];

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 16; i++)
        mem_q[i] <= WREG_RST;
      rf.ra_data <= WREG_RST;
      rf.rb_data <= WREG_RST;
      rf.rc_data <= WREG_RST;
      rf.rd_data <= WREG_RST;
    end
    else
    begin
      if (rf.we0)
        mem_q[rf.wa0] <= rf.wd0;
      if (rf.we1)
        mem_q[rf.wa1] <= rf.wd1;
      rf.ra_data <= mem_q[rf.ra_addr];
      rf.rb_data <= mem_q[rf.rb_addr];
      rf.rc_data <= mem_q[rf.rc_addr];
      rf.rd_data <= mem_q[rf.rd_addr];
    end
  end

endmodule // work_reg_file

// ==== logic/cpu_alu_status_datapath.sv ====
// CPU arithmetic datapath with status and core control registers.
// Assumes the decoder issues one operation at a time on a valid/ready
// handshake and software reaches the registers over Avalon-MM.
//
// Notes on behaviour
// - 16-bit unit does two's complement add, subtract, shifts, logic.
// - Byte or word operands; sources and results in registers or memory.
// - Half carry at bit 8: carry out of bit 3 (byte) or 7 (word).
// - Carry at bit 0 is the carry out of the result's top bit.
// - On subtract, carry and half carry act as inverted borrows.
// - Negative at bit 3 copies the sign of the result.
// - Overflow at bit 2 flags signed two's complement overflow.
// - Zero at bit 1 is set when the result equals zero.
// - Only operations defined to affect a flag update it.
// - Loop active at bit 4 reads 1 during a repeat loop, read-only.
// - Bits 7-5 hold priority level 0-7; level 7 blocks user interrupts.
// - Priority field is read-only while nesting disable is 1.
// - Control bit 3 is the top bit of a 4-bit priority level.
// - Control bit 3 resets to 0; software may clear but never set it.
// - Unused bits read 0; control bit 2 reads 1.
// - 17x17 multiplier: sign-mixed 16x16, 16x5 literal, 8x8 unsigned.
// - Divide 32/16 and 16/16, signed and unsigned.
// - Quotient goes to register 0, remainder to register 1.
// - Divisor any register; dividend any aligned pair, odd is high.
// - One divide step per divisor bit, same length for both sizes.
// - Barrel shifter: arithmetic right, logical right, left, 0-15 bits.
// - Multibit shifts use register operands and destination only.
`timescale 1ns/100ps
module cpu_alu_status_datapath
  import alu_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register bus
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Instruction issue
  input wire logic op_valid,
  output logic op_ready,
  input op_t op_code,
  input wire logic op_byte,
  input wire logic [3:0] op_dst,
  input wire logic [3:0] op_src_a,
  input wire logic [3:0] op_src_b,
  input wire logic op_use_lit,
  input wire logic [15:0] op_lit,
  input wire logic op_mem_src,
  input wire logic op_mem_dst,
  input wire logic [15:0] mem_rdata,
  // Data memory write
  output logic mem_we,
  output logic mem_byte,
  output logic [15:0] mem_wdata,
  // Core status
  input wire logic loop_active,
  input wire logic nest_disable,
  input wire logic prio_top_set,
  output logic [3:0] priority_level,
  output logic user_int_block
);

  regfile_if rf ();

  work_reg_file u_regs (
    .core_clk (core_clk),
    .sys_rst (sys_rst),
    .rf (rf.mem)
  );

  state_t state_q;
  state_t state_d;
  op_t op_q;
  logic byte_q, use_lit_q, mem_src_q, mem_dst_q;
  logic [3:0] dst_q;
  logic [15:0] lit_q, mrd_q;
  logic c_q, z_q, ov_q, n_q, dc_q, top_q;
  logic [2:0] ipl_q;
  logic [16:0] rem_q;
  logic [15:0] quo_q, dvs_q;
  logic qneg_q, rneg_q;
  logic [3:0] cnt_q;
  logic [1:0] bus_cnt_q;
  logic [15:0] res;
  logic sh_c;

  // Register bus: every access answers on its third cycle
  wire bus_req = avs_read | avs_write;
  wire bus_last = bus_cnt_q == 2'h2;
  wire sel_status = avs_address == STATUS_OFS;
  wire sel_control = avs_address == CONTROL_OFS;
  wire sel_wreg = avs_address[6] == WREG_BASE[6];
  wire st_wr = avs_write & bus_last & sel_status;
  wire ct_wr = avs_write & bus_last & sel_control;
  wire [15:0] status_rd = {7'h00, dc_q, ipl_q, loop_active,
                           n_q, ov_q, z_q, c_q};
  wire [15:0] ctrl_rd = {12'h000, top_q, CTRL_RSVD_VAL, 2'h0};
  wire [15:0] bus_rd = sel_status ? status_rd :
                       sel_control ? ctrl_rd :
                       sel_wreg ? rf.rd_data : 16'h0000;
  assign avs_waitrequest = bus_req & ~bus_last;

  // Issue and decode
  wire exec = state_q == ST_EXEC;
  wire op_go = op_valid & op_ready;
  wire go_div = is_div(op_code);
  wire go_plain = is_div(op_code) | is_mul(op_code) | is_mbshift(op_code);
  assign op_ready = state_q == ST_IDLE;
  // Divide reads its dividend pair on ports a and c
  assign rf.ra_addr = go_div ? {op_src_a[3:1], 1'b0} : op_src_a;
  assign rf.rc_addr = go_div ? {op_src_a[3:1], 1'b1} : op_dst;
  assign rf.rb_addr = op_src_b;
  assign rf.rd_addr = avs_address[5:2];

  // Operands
  wire [15:0] opa = mem_src_q ? mrd_q : rf.ra_data;
  wire [15:0] opb = use_lit_q ? lit_q : rf.rb_data;
  wire [3:0] amt = opb[3:0];
  wire is_sub = op_q == OP_SUB;
  wire is_addsub = op_q inside {OP_ADD, OP_SUB};
  wire is_logic = op_q inside {OP_AND, OP_IOR, OP_XOR};
  wire is_sh1 = op_q inside {OP_SL1, OP_LSR1, OP_ASR1};
  // Subtract as a + ~b + 1, so carries read as inverted borrows
  wire arith_t arith = add_fn(opa, is_sub ? ~opb : opb, is_sub,
                              byte_q);

  // Multiplier
  wire mul32 = is_mul(op_q) & (op_q != OP_MUL_BB);
  wire mul_lit = op_q inside {OP_MUL_SL, OP_MUL_UL};
  wire mul_as = op_q inside {OP_MUL_SS, OP_MUL_SU, OP_MUL_SL};
  wire mul_bs = op_q inside {OP_MUL_SS, OP_MUL_US};
  wire [15:0] mul_a = op_q == OP_MUL_BB ? {8'h00, opa[7:0]} : opa;
  wire [15:0] mul_b = mul_lit ? {11'h000, opb[4:0]} :
                      op_q == OP_MUL_BB ? {8'h00, opb[7:0]} : opb;
  wire [31:0] prod = mul_fn(mul_a, mul_b, mul_as, mul_bs);

  always_comb
  begin
    res = opb;
    sh_c = 1'b0;
    case (op_q)
      OP_ADD, OP_SUB: res = arith.res;
      OP_AND: res = opa & opb;
      OP_IOR: res = opa | opb;
      OP_XOR: res = opa ^ opb;
      OP_SL1:
      begin
        res = {opa[14:0], 1'b0};
        sh_c = byte_q ? opa[7] : opa[15];
      end
      OP_LSR1:
      begin
        res = byte_q ? {9'h000, opa[7:1]} : {1'b0, opa[15:1]};
        sh_c = opa[0];
      end
      OP_ASR1:
      begin
        res = byte_q ? {8'h00, opa[7], opa[7:1]} : {opa[15], opa[15:1]};
        sh_c = opa[0];
      end
      OP_SHL: res = opa << amt;
      OP_LSR: res = opa >> amt;
      OP_ASR: res = 16'($signed(opa) >>> amt);
      OP_MUL_BB: res = prod[15:0];
      default: res = opb;
    endcase
  end

  // Byte results replace only the low byte of the destination
  wire [15:0] wr_val = byte_q ? {rf.rc_data[15:8], res[7:0]} : res;
  wire n_new = byte_q ? res[7] : res[15];
  wire z_new = byte_q ? res[7:0] == 8'h00 : res == 16'h0000;
  wire upd_arith = exec & is_addsub;
  wire upd_c = upd_arith | (exec & is_sh1);
  wire upd_nz = exec & (is_addsub | is_logic | is_sh1 |
                        is_mbshift(op_q));

  // Divider setup, on magnitudes with the signs fixed at the end
  wire div_wide = op_q inside {OP_DIV_S32, OP_DIV_U32};
  wire div_sgn = op_q inside {OP_DIV_S32, OP_DIV_S16};
  wire [31:0] dividend = div_wide ? {rf.rc_data, rf.ra_data} :
                         {{16{div_sgn & rf.ra_data[15]}}, rf.ra_data};
  wire n_neg = div_sgn & dividend[31];
  wire d_neg = div_sgn & rf.rb_data[15];
  wire [31:0] n_mag = n_neg ? 32'(-dividend) : dividend;
  wire [15:0] d_mag = d_neg ? 16'(-rf.rb_data) : rf.rb_data;
  wire [16:0] shifted = {rem_q[15:0], quo_q[15]};
  wire div_ge = shifted >= {1'b0, dvs_q};
  wire [16:0] rem_nx = div_ge ? 17'(shifted - {1'b0, dvs_q}) : shifted;
  wire [15:0] quo_nx = {quo_q[14:0], div_ge};
  wire [15:0] quo_fin = qneg_q ? 16'(-quo_nx) : quo_nx;
  wire [15:0] rem_fin = rneg_q ? 16'(-rem_nx[15:0]) : rem_nx[15:0];
  wire div_last = (state_q == ST_DIV) & (cnt_q == DIV_LAST);

  // Register array writes
  wire reg_wr = exec & ~mem_dst_q & ~is_div(op_q);
  assign rf.we0 = div_last | reg_wr;
  assign rf.wa0 = div_last ? QUOT_REG :
                  mul32 ? {dst_q[3:1], 1'b0} : dst_q;
  assign rf.wd0 = div_last ? quo_fin : mul32 ? prod[15:0] : wr_val;
  assign rf.we1 = div_last | (exec & mul32);
  assign rf.wa1 = div_last ? REM_REG : {dst_q[3:1], 1'b1};
  assign rf.wd1 = div_last ? rem_fin : prod[31:16];

  assign priority_level = {top_q, ipl_q};
  assign user_int_block = top_q | (ipl_q == 3'h7);

  always_comb
  begin
    case (state_q)
      ST_IDLE: state_d = op_go ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_d = is_div(op_q) ? ST_DIV : ST_IDLE;
      ST_DIV: state_d = div_last ? ST_IDLE : ST_DIV;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      bus_cnt_q <= 2'h0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      state_q <= state_d;
      bus_cnt_q <= (bus_req & ~bus_last) ? 2'(bus_cnt_q + 2'h1) : 2'h0;
      if (avs_read & (bus_cnt_q == 2'h1))
        avs_readdata <= {16'h0000, bus_rd};
    end
  end

  // Captured operation; multibit shifts drop any memory addressing
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      op_q <= OP_MOV;
      byte_q <= 1'b0;
      use_lit_q <= 1'b0;
      mem_src_q <= 1'b0;
      mem_dst_q <= 1'b0;
      dst_q <= 4'h0;
      lit_q <= 16'h0000;
      mrd_q <= 16'h0000;
    end
    else if (op_go)
    begin
      op_q <= op_code;
      byte_q <= op_byte & ~go_plain;
      use_lit_q <= op_use_lit;
      mem_src_q <= op_mem_src & ~is_mbshift(op_code);
      mem_dst_q <= op_mem_dst & ~go_plain;
      dst_q <= op_dst;
      lit_q <= op_lit;
      mrd_q <= mem_rdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      mem_we <= 1'b0;
      mem_byte <= 1'b0;
      mem_wdata <= 16'h0000;
    end
    else
    begin
      mem_we <= exec & mem_dst_q;
      mem_byte <= byte_q;
      mem_wdata <= res;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rem_q <= 17'h00000;
      quo_q <= 16'h0000;
      dvs_q <= 16'h0000;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
      cnt_q <= 4'h0;
    end
    else if (exec)
    begin
      rem_q <= {1'b0, n_mag[31:16]};
      quo_q <= n_mag[15:0];
      dvs_q <= d_mag;
      qneg_q <= n_neg ^ d_neg;
      rneg_q <= n_neg;
      cnt_q <= 4'h0;
    end
    else if (state_q == ST_DIV)
    begin
      rem_q <= rem_nx;
      quo_q <= quo_nx;
      cnt_q <= 4'(cnt_q + 4'h1);
    end
  end

  // Status flags: the datapath wins over a software write in one cycle
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      c_q <= FLAG_RST;
      z_q <= FLAG_RST;
      ov_q <= FLAG_RST;
      n_q <= FLAG_RST;
      dc_q <= FLAG_RST;
      ipl_q <= IPL_RST;
    end
    else
    begin
      if (upd_c)
        c_q <= is_addsub ? arith.c : sh_c;
      else if (st_wr & avs_byteenable[0])
        c_q <= avs_writedata[C_BIT];
      if (upd_nz)
        z_q <= z_new;
      else if (st_wr & avs_byteenable[0])
        z_q <= avs_writedata[Z_BIT];
      if (upd_nz)
        n_q <= n_new;
      else if (st_wr & avs_byteenable[0])
        n_q <= avs_writedata[N_BIT];
      if (upd_arith)
        ov_q <= arith.ov;
      else if (st_wr & avs_byteenable[0])
        ov_q <= avs_writedata[OV_BIT];
      if (upd_arith)
        dc_q <= arith.dc;
      else if (st_wr & avs_byteenable[1])
        dc_q <= avs_writedata[DC_BIT];
      if (st_wr & avs_byteenable[0] & ~nest_disable)
        ipl_q <= avs_writedata[IPL_MSB:IPL_LSB];
    end
  end

  // Top priority bit: set only by the exception side, set beats clear
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      top_q <= TOP_RST;
    else if (prio_top_set)
      top_q <= 1'b1;
    else if (ct_wr & avs_byteenable[0] & ~avs_writedata[TOP_BIT])
      top_q <= 1'b0;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  wire [16:0] add_chk = {1'b0, opa} + {1'b0, opb};
  wire [4:0] nib_chk = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};

  sequence s_div_start;
    op_valid && op_ready && is_div(op_code);
  endsequence
  sequence s_div_busy;
    !op_ready [*8] ##1 !op_ready [*8] ##1 !op_ready;
  endsequence

  property p_div_len;
    s_div_start |=> s_div_busy ##1 op_ready;
  endproperty
  a_div_len: assert property (p_div_len)
    else $error("divide did not take sixteen steps");
  property p_div_dest;
    s_div_start |-> ##17 (rf.we0 && rf.wa0 == QUOT_REG &&
                          rf.we1 && rf.wa1 == REM_REG);
  endproperty
  a_div_dest: assert property (p_div_dest)
    else $error("divide results not written to registers 0 and 1");
  property p_add_carry;
    exec && op_q == OP_ADD && !byte_q |=> c_q == $past(add_chk[16]);
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("word add carry wrong");
  property p_sub_borrow;
    exec && is_sub && !byte_q |=> c_q == $past(opa >= opb);
  endproperty
  a_sub_borrow: assert property (p_sub_borrow)
    else $error("subtract borrow wrong");
  property p_dc_byte;
    exec && op_q == OP_ADD && byte_q |=> dc_q == $past(nib_chk[4]);
  endproperty
  a_dc_byte: assert property (p_dc_byte)
    else $error("byte half carry wrong");
  property p_ov_add;
    exec && op_q == OP_ADD && !byte_q |=>
      ov_q == $past(opa[15] == opb[15] && add_chk[15] != opa[15]);
  endproperty
  a_ov_add: assert property (p_ov_add)
    else $error("word add overflow wrong");
  property p_zero_neg;
    upd_nz && !byte_q |=> z_q == ($past(res) == 16'h0000) &&
                          n_q == $past(res[15]);
  endproperty
  a_zero_neg: assert property (p_zero_neg)
    else $error("zero or negative flag wrong");
  property p_mul_keep;
    exec && is_mul(op_q) && !st_wr |=> $stable({c_q, z_q, n_q, ov_q, dc_q});
  endproperty
  a_mul_keep: assert property (p_mul_keep)
    else $error("multiply changed a flag");
  property p_ipl_lock;
    nest_disable && st_wr |=> $stable(ipl_q);
  endproperty
  a_ipl_lock: assert property (p_ipl_lock)
    else $error("priority field written while locked");
  property p_top_noset;
    ct_wr && !prio_top_set && !top_q |=> !top_q;
  endproperty
  a_top_noset: assert property (p_top_noset)
    else $error("software set the top priority bit");
  property p_ctrl_read;
    avs_read && !avs_waitrequest && sel_control |->
      avs_readdata[CTRL_RSVD_BIT] && avs_readdata[31:4] == 28'h0000000 &&
      avs_readdata[1:0] == 2'h0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control register fixed bits wrong");
  property p_ra_read;
    avs_read && !avs_waitrequest && sel_status |->
      avs_readdata[RA_BIT] == $past(loop_active);
  endproperty
  a_ra_read: assert property (p_ra_read)
    else $error("loop active bit does not follow the loop");

endmodule // cpu_alu_status_datapath

// ==== testbench/data_mem_model.sv ====
// Data memory store side facing the datapath; keeps the last word.
// Assumes the bench supplies memory read data in the memory's place.
`timescale 1ns/100ps
module data_mem_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Store port
  input wire logic mem_we,
  input wire logic [15:0] mem_wdata,
  // Observation
  output logic [15:0] last_q,
  output logic [7:0] writes_q
);
  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      last_q <= 16'h0000;
      writes_q <= 8'h00;
    end
    else if (mem_we)
    begin
      last_q <= mem_wdata;
      writes_q <= writes_q + 8'h01;
    end
endmodule // data_mem_model

// ==== testbench/test_cpu_alu_status_datapath.sv ====
// Self-checking bench for the arithmetic datapath and its registers.
// Assumes Avalon-MM answers and op_ready timing as handed over.
`timescale 1ns/100ps
module test_cpu_alu_status_datapath
  import alu_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic avs_read = 1'b0, avs_write = 1'b0, op_valid = 1'b0, op_byte = 1'b0;
  logic op_use_lit = 1'b0, op_mem_src = 1'b0, op_mem_dst = 1'b0;
  logic loop_active = 1'b0, nest_disable = 1'b0, prio_top_set = 1'b0;
  logic [6:0] avs_address = 7'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] op_dst = 4'h0, op_src_a = 4'h0, op_src_b = 4'h0;
  logic [15:0] op_lit = 16'h0, mem_rdata = 16'h0, mem_wdata, last_q, rd;
  op_t op_code = OP_MOV;
  logic avs_waitrequest, op_ready, mem_we, mem_byte, user_int_block;
  logic [3:0] priority_level;
  logic [7:0] writes_q;
  logic [15:0] regs [16];
  logic [4:0] fl;
  logic [2:0] ipl;
  int mismatches = 0, checks_done = 0, n;
  cpu_alu_status_datapath dut (.avs_byteenable(4'hF), .*);
  data_mem_model u_mem (.*);
  initial forever #25 core_clk = ~core_clk;
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits on waitrequest only; the answer latency is not assumed
  task automatic bus(input logic w, input logic [6:0] a,
                     input logic [15:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    do
    begin
      @(posedge core_clk);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    chk(rd, exp);
  endtask
  function automatic logic [15:0] st();
    return {7'h00, fl[4], ipl, loop_active, fl[3:0]};
  endfunction
  // Leaves n as the count of cycles with op_ready low
  task automatic op(input op_t c, input logic byt, input logic [3:0] d,
                    input logic [3:0] a, input logic [3:0] b,
                    input logic ul, input logic [15:0] lit,
                    input logic ms, input logic [15:0] md);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_byte <= byt;
    op_dst <= d;
    op_src_a <= a;
    op_src_b <= b;
    op_use_lit <= ul;
    op_lit <= lit;
    op_mem_src <= ms;
    mem_rdata <= md;
    @(posedge core_clk);
    op_valid <= 1'b0;
    mem_rdata <= ~md;
    n = 0;
    @(posedge core_clk);
    while (op_ready !== 1'b1)
    begin
      n++;
      @(posedge core_clk);
    end
  endtask
  // Subtract carries are inverted borrows, as chosen by the designer
  task automatic alu(input op_t c, input logic byt, input logic [3:0] d,
                     input logic [15:0] a, input logic [15:0] b);
    logic [15:0] bb, r;
    logic [16:0] s;
    logic [8:0] lo;
    logic [4:0] nb;
    logic ci, ar;
    ci = (c == OP_SUB);
    ar = ci || (c == OP_ADD);
    bb = ci ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {16'h0000, ci};
    lo = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, ci};
    nb = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    r = (c == OP_AND) ? a & b : (c == OP_IOR) ? a | b :
        (c == OP_XOR) ? a ^ b : s[15:0];
    if (ar)
      fl[4] = byt ? nb[4] : lo[8];
    fl[3] = byt ? r[7] : r[15];
    if (ar)
      fl[2] = byt ? (a[7] == bb[7] && r[7] != a[7]) :
                    (a[15] == bb[15] && r[15] != a[15]);
    fl[1] = byt ? (r[7:0] == 8'h00) : (r == 16'h0000);
    if (ar)
      fl[0] = byt ? lo[8] : s[16];
    regs[d] = byt ? {regs[d][15:8], r[7:0]} : r;
  endtask
  initial
  begin
    #2000000;
    mismatches++;
    final_report;
  end
  initial
  begin
    op_t tbl [5];
    op_t c;
    logic byt, ul;
    logic [3:0] d, sb;
    logic [15:0] x, y, keep, r;
    logic [31:0] p;
    int k;
    tbl = '{OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR};
    void'($urandom(36592));
    foreach (regs[i])
      regs[i] = 16'h0000;
    fl = 5'h00;
    ipl = 3'h0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    rchk(STATUS_OFS, 16'h0000);
    rchk(CONTROL_OFS, 16'h0004);
    rchk(7'h10, 16'h0000);
    for (int i = 0; i < 40; i++)
    begin
      c = tbl[$urandom_range(4)];
      byt = 1'($urandom);
      ul = 1'($urandom);
      d = 4'($urandom_range(7, 2));
      sb = 4'($urandom_range(7, 2));
      x = 16'($urandom);
      y = 16'($urandom);
      // Carry out with zero result, then signed overflow on subtract
      if (i < 2)
      begin
        c = i ? OP_SUB : OP_ADD;
        {byt, ul, y} = {2'h1, 16'h0001};
        x = i ? 16'h8000 : 16'hFFFF;
      end
      op(c, byt, d, 4'h0, sb, ul, y, 1'b1, x);
      chk(16'(n), 16'h0001);
      alu(c, byt, d, x, ul ? y : regs[sb]);
      rchk(WREG_BASE + 7'(4 * d), regs[d]);
      rchk(STATUS_OFS, st());
    end
    op_mem_dst <= 1'b1;
    op(OP_ADD, 1'b0, 4'h3, 4'h0, 4'h0, 1'b1, 16'h1234, 1'b1, 16'h0F0F);
    op_mem_dst <= 1'b0;
    @(negedge core_clk);
    keep = regs[3];
    alu(OP_ADD, 1'b0, 4'h3, 16'h0F0F, 16'h1234);
    chk(last_q, regs[3]);
    chk(16'(writes_q), 16'h0001);
    regs[3] = keep;
    rchk(WREG_BASE + 7'h0C, keep);
    for (int i = 0; i < 2; i++)
    begin
      op(i ? OP_MUL_SS : OP_MUL_UU, 1'b0, 4'h8, 4'h2, 4'h3, 1'b0,
         16'h0000, 1'b0, 16'h0000);
      if (i)
        p = $signed(regs[2]) * $signed(regs[3]);
      else
        p = regs[2] * regs[3];
      {regs[9], regs[8]} = p;
      rchk(WREG_BASE + 7'h20, regs[8]);
      rchk(WREG_BASE + 7'h24, regs[9]);
      rchk(STATUS_OFS, st());
    end
    for (int i = 0; i < 3; i++)
    begin
      k = i ? $urandom_range(15) : 15;
      c = i == 0 ? OP_ASR : i == 1 ? OP_LSR : OP_SHL;
      op(c, 1'b0, 4'hA, 4'h9, 4'h0, 1'b1, 16'(k), 1'b0, 16'h0000);
      case (i)
        0: r = $signed(regs[9]) >>> k;
        1: r = regs[9] >> k;
        default: r = regs[9] << k;
      endcase
      regs[10] = r;
      fl[3] = r[15];
      fl[1] = (r == 16'h0000);
      rchk(WREG_BASE + 7'h28, r);
      rchk(STATUS_OFS, st());
    end
    x = 16'($urandom);
    y = 16'($urandom_range(65535, 1));
    op(OP_ADD, 1'b0, 4'h4, 4'h0, 4'h0, 1'b1, 16'h0000, 1'b1, x);
    alu(OP_ADD, 1'b0, 4'h4, x, 16'h0000);
    op(OP_ADD, 1'b0, 4'h5, 4'h0, 4'h0, 1'b1, 16'h0000, 1'b1, 16'h0000);
    alu(OP_ADD, 1'b0, 4'h5, 16'h0000, 16'h0000);
    op(OP_ADD, 1'b0, 4'h6, 4'h0, 4'h0, 1'b1, y, 1'b1, 16'h0000);
    alu(OP_ADD, 1'b0, 4'h6, 16'h0000, y);
    op(OP_DIV_U32, 1'b0, 4'h0, 4'h4, 4'h6, 1'b0, 16'h0000, 1'b0, 16'h0000);
    chk(16'(n), 16'h0011);
    regs[0] = x / y;
    regs[1] = x % y;
    rchk(WREG_BASE, regs[0]);
    rchk(WREG_BASE + 7'h04, regs[1]);
    op(OP_DIV_S16, 1'b0, 4'h0, 4'h4, 4'h6, 1'b0, 16'h0000, 1'b0, 16'h0000);
    regs[0] = 16'($signed(x) / $signed(y));
    regs[1] = 16'($signed(x) % $signed(y));
    rchk(WREG_BASE, regs[0]);
    rchk(WREG_BASE + 7'h04, regs[1]);
    loop_active <= 1'b1;
    rchk(STATUS_OFS, {7'h00, fl[4], ipl, 1'b1, fl[3:0]});
    loop_active <= 1'b0;
    bus(1'b1, STATUS_OFS, 16'hFFFF);
    fl = 5'h1F;
    ipl = 3'h7;
    rchk(STATUS_OFS, st());
    chk(16'(user_int_block), 16'h0001);
    nest_disable <= 1'b1;
    bus(1'b1, STATUS_OFS, 16'h0000);
    fl = 5'h00;
    rchk(STATUS_OFS, st());
    nest_disable <= 1'b0;
    bus(1'b1, STATUS_OFS, 16'h0000);
    ipl = 3'h0;
    bus(1'b1, CONTROL_OFS, 16'hFFFF);
    rchk(CONTROL_OFS, 16'h0004);
    prio_top_set <= 1'b1;
    @(posedge core_clk);
    prio_top_set <= 1'b0;
    rchk(CONTROL_OFS, 16'h000C);
    chk(16'(priority_level), 16'h0008);
    bus(1'b1, CONTROL_OFS, 16'h0000);
    rchk(CONTROL_OFS, 16'h0004);
    bus(1'b1, WREG_BASE, 16'hA5A5);
    rchk(WREG_BASE, regs[0]);
    final_report;
  end
endmodule // test_cpu_alu_status_datapath
